// ===== common/prc_pkg.sv
// Package for the portrait rotation control block: offsets, fields, types
package prc_pkg;
  localparam int ADDR_W = 8;
  localparam int MEM_AW = 17;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_START_LOW = 6'h0c;
  localparam logic [5:0] IDX_START_MID = 6'h0d;
  localparam logic [5:0] IDX_START_TOP = 6'h0e;
  localparam logic [5:0] IDX_ROT_CTRL = 6'h1b;
  localparam logic [5:0] IDX_STRIDE = 6'h1c;
  localparam logic [5:0] IDX_CFG = 6'h20;
  localparam logic [5:0] IDX_STATUS = 6'h21;
  // Rotation control fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ALT = 6;
  localparam int BIT_MCLK_SEL = 2;
  localparam logic [7:0] ROT_WR_MASK = 8'hc7;
  localparam logic [7:0] TOP_WR_MASK = 8'h01;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_SIZE = 16'h0140;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
  localparam logic [1:0] MCLK_DIV_SLOW = 2'h1;
  localparam logic [1:0] MCLK_DIV_FAST = 2'h0;

  typedef struct packed {
    logic enable;
    logic alt;
    logic mclk_sel;
    logic [1:0] pclk_sel;
  } prc_rot_t;

  typedef struct packed {
    logic valid;
    logic first_line;
    logic [MEM_AW-1:0] addr;
  } prc_fetch_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SCAN = 3'b010,
    ST_WRAP = 3'b100
  } prc_state_t;
endpackage : prc_pkg

// ===== verilog/prc_rotation_ctrl.sv
// Portrait rotation control: registers, clock options and rotated refresh addressing
`timescale 1ns/10ps
// Operation
// RQ1: Enable clear means landscape, settings ignored
// RQ2: Select bit picks default or alternate scheme
// RQ3: Software uses power of two width
// RQ4: Default scheme scrolls in two-line steps
// RQ5: Alternate scheme scrolls one line at a time
// RQ6: Alternate needs twice the input clock
// RQ7: Portrait refresh scans columns from row end
// RQ8: Start value is byte offset in portrait
// RQ9: Software loads start with stride minus one
// RQ10: Stride register spaces lines in portrait only
// RQ11: Memory clock boosts during CPU access
// RQ12: Boost allowed only at 25 MHz or less
// RQ13: Input clock feeds portrait clock, memory derived
// RQ14: Bit 7 enables, bit 6 selects scheme
// RQ15: Bit 2 makes memory clock equal portrait
// RQ16: No second screen during portrait
// RQ17: Bits 1-0 pixel clock select, 5-3 zero
module prc_rotation_ctrl #(
  parameter logic [15:0] PANEL_LINES = 16'h00f0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [prc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_mem_access,
  input wire logic split_active,
  output logic portrait_mode,
  output logic alt_scheme,
  output logic [1:0] pclk_div_sel,
  output logic [1:0] mclk_div_sel,
  output logic second_screen_en,
  output logic [prc_pkg::MEM_AW-1:0] fetch_addr,
  output logic fetch_valid,
  output logic fetch_first_line
);
  logic [7:0] start_low_q;
  logic [7:0] start_mid_q;
  logic start_top_q;
  prc_pkg::prc_rot_t rot_q;
  logic [7:0] stride_q;
  logic [15:0] panel_cols_q;
  logic run_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic cpu_s1_q;
  logic cpu_s2_q;
  logic split_s1_q;
  logic split_s2_q;
  prc_pkg::prc_state_t state_q;
  logic [15:0] col_q;
  logic [15:0] row_q;
  logic [prc_pkg::MEM_AW-1:0] start_byte_q;
  prc_pkg::prc_fetch_t fetch_q;
  logic [1:0] mclk_q;
  logic [1:0] pclk_q;
  logic portrait_q;
  logic alt_q;
  logic split_q;

  logic [5:0] idx;
  logic wr_now;
  logic rd_now;
  logic [7:0] wbyte;
  logic [prc_pkg::MEM_AW-1:0] start_raw;
  logic [prc_pkg::MEM_AW-1:0] start_eff;
  logic [prc_pkg::MEM_AW-1:0] line_base;
  logic [prc_pkg::MEM_AW-1:0] row_off;

  assign idx = avs_address[7:2];
  assign wbyte = avs_writedata[7:0];
  // One wait cycle, then the acknowledge; a request is taken only when acked
  assign wr_now = avs_write && ack_q;
  assign rd_now = avs_read && ack_q;
  assign start_raw = {start_top_q, start_mid_q, start_low_q};

  // Bus handshake: waitrequest drops for one cycle per request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // Waitrequest is registered and low only in the acknowledge cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // Register writes, gated by byte enable 0; lane 0 carries data except CFG, which takes bits 15-0
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_low_q <= prc_pkg::RESET_BYTE;
      start_mid_q <= prc_pkg::RESET_BYTE;
      start_top_q <= 1'b0;
      rot_q <= '0;
      stride_q <= prc_pkg::RESET_BYTE;
      panel_cols_q <= prc_pkg::RESET_SIZE;
    end else if (wr_now && avs_byteenable[0]) begin
      if (idx == prc_pkg::IDX_START_LOW) begin
        start_low_q <= wbyte;
      end else if (idx == prc_pkg::IDX_START_MID) begin
        start_mid_q <= wbyte;
      end else if (idx == prc_pkg::IDX_START_TOP) begin
        start_top_q <= wbyte[0]; // [RQ8]
      end else if (idx == prc_pkg::IDX_ROT_CTRL) begin
        rot_q.enable <= wbyte[prc_pkg::BIT_ENABLE]; // [RQ14]
        rot_q.alt <= wbyte[prc_pkg::BIT_ALT]; // [RQ14]
        rot_q.mclk_sel <= wbyte[prc_pkg::BIT_MCLK_SEL]; // [RQ15]
        rot_q.pclk_sel <= wbyte[1:0]; // [RQ17]
      end else if (idx == prc_pkg::IDX_STRIDE) begin
        stride_q <= wbyte; // [RQ10]
      end else if (idx == prc_pkg::IDX_CFG) begin
        panel_cols_q <= avs_writedata[15:0];
      end
    end
  end

  // Read data; unmapped addresses and reserved bits read as zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= prc_pkg::UNMAPPED_DATA;
    end else if ((avs_read || avs_write) && !ack_q) begin
      if (idx == prc_pkg::IDX_START_LOW) begin
        rdata_q <= {24'h000000, start_low_q};
      end else if (idx == prc_pkg::IDX_START_MID) begin
        rdata_q <= {24'h000000, start_mid_q};
      end else if (idx == prc_pkg::IDX_START_TOP) begin
        rdata_q <= {24'h000000, 7'h00, start_top_q};
      end else if (idx == prc_pkg::IDX_ROT_CTRL) begin
        rdata_q <= {24'h000000, rot_q.enable, rot_q.alt, 3'h0, rot_q.mclk_sel, rot_q.pclk_sel}; // [RQ17]
      end else if (idx == prc_pkg::IDX_STRIDE) begin
        rdata_q <= {24'h000000, stride_q};
      end else if (idx == prc_pkg::IDX_CFG) begin
        rdata_q <= {16'h0000, panel_cols_q};
      end else if (idx == prc_pkg::IDX_STATUS) begin
        rdata_q <= {run_q, 1'b0, mclk_q, row_q[11:0], col_q};
      end else begin
        rdata_q <= prc_pkg::UNMAPPED_DATA;
      end
    end
  end
  assign avs_readdata = rdata_q;

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_s1_q <= 1'b0;
      cpu_s2_q <= 1'b0;
      split_s1_q <= 1'b0;
      split_s2_q <= 1'b0;
    end else begin
      cpu_s1_q <= cpu_mem_access;
      cpu_s2_q <= cpu_s1_q;
      split_s1_q <= split_active;
      split_s2_q <= split_s1_q;
    end
  end

  // Clock selections; sys_clk stands for the input clock routed as portrait clock
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      portrait_q <= 1'b0;
      alt_q <= 1'b0;
      pclk_q <= 2'h0;
      mclk_q <= prc_pkg::MCLK_DIV_SLOW;
      split_q <= 1'b0;
    end else begin
      portrait_q <= rot_q.enable; // [RQ1]
      alt_q <= rot_q.enable && rot_q.alt; // [RQ2]
      // Settings are ignored in landscape
      pclk_q <= rot_q.enable ? rot_q.pclk_sel : 2'h0; // [RQ1] [RQ13] [RQ17]
      if (!rot_q.enable) begin
        mclk_q <= prc_pkg::MCLK_DIV_SLOW;
      end else if (rot_q.mclk_sel && cpu_s2_q) begin
        mclk_q <= prc_pkg::MCLK_DIV_FAST; // [RQ11] [RQ15]
      end else begin
        mclk_q <= prc_pkg::MCLK_DIV_SLOW; // [RQ11] [RQ13]
      end
      split_q <= split_s2_q && !rot_q.enable; // [RQ16]
    end
  end
  assign portrait_mode = portrait_q;
  assign alt_scheme = alt_q;
  assign pclk_div_sel = pclk_q;
  assign mclk_div_sel = mclk_q;
  assign second_screen_en = split_q;

  // Default scheme drops the low start bit, so scrolling moves two lines at once
  assign start_eff = rot_q.alt ? start_raw : {start_raw[prc_pkg::MEM_AW-1:1], 1'b0}; // [RQ4] [RQ5]
  assign row_off = prc_pkg::MEM_AW'(row_q);
  assign line_base = start_byte_q - row_off; // [RQ7]

  // Rotated refresh: each panel line walks down memory rows, stepping by stride
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= prc_pkg::ST_IDLE;
      run_q <= 1'b0;
      col_q <= 16'h0000;
      row_q <= 16'h0000;
      start_byte_q <= '0;
      fetch_q <= '0;
    end else begin
      case (state_q)
        prc_pkg::ST_IDLE: begin
          fetch_q <= '0;
          run_q <= 1'b0;
          if (rot_q.enable) begin // [RQ1]
            start_byte_q <= start_eff; // [RQ8]
            col_q <= 16'h0000;
            row_q <= 16'h0000;
            run_q <= 1'b1;
            state_q <= prc_pkg::ST_SCAN;
          end
        end
        prc_pkg::ST_SCAN: begin
          if (!rot_q.enable) begin
            fetch_q <= '0;
            state_q <= prc_pkg::ST_IDLE;
          end else begin
            fetch_q.valid <= 1'b1;
            fetch_q.first_line <= (row_q == 16'h0000);
            // Start at the end of the first memory row and move one row down per pixel
            fetch_q.addr <= line_base + prc_pkg::MEM_AW'(col_q) * prc_pkg::MEM_AW'(stride_q); // [RQ7] [RQ10]
            if (col_q == panel_cols_q - 16'h0001) begin
              col_q <= 16'h0000;
              state_q <= prc_pkg::ST_WRAP;
            end else begin
              col_q <= col_q + 16'h0001;
            end
          end
        end
        prc_pkg::ST_WRAP: begin
          fetch_q.valid <= 1'b0;
          if (row_q == PANEL_LINES - 16'h0001) begin
            // New frame picks up the latest start offset
            row_q <= 16'h0000;
            start_byte_q <= start_eff; // [RQ4] [RQ5]
          end else begin
            row_q <= row_q + 16'h0001;
          end
          state_q <= rot_q.enable ? prc_pkg::ST_SCAN : prc_pkg::ST_IDLE;
        end
        default: begin
          state_q <= prc_pkg::ST_IDLE;
        end
      endcase
    end
  end
  assign fetch_addr = fetch_q.addr;
  assign fetch_valid = fetch_q.valid;
  assign fetch_first_line = fetch_q.first_line;
endmodule : prc_rotation_ctrl

// ===== tb/prc_properties.sv
// Checker for the portrait rotation control block
`timescale 1ns/10ps
module prc_properties (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [prc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic cpu_mem_access,
  input wire logic portrait_mode,
  input wire logic alt_scheme,
  input wire logic [1:0] pclk_div_sel,
  input wire logic [1:0] mclk_div_sel,
  input wire logic second_screen_en,
  input wire logic fetch_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic rd_ok;
  assign rd_ok = avs_read && !avs_waitrequest;
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest missed its answer cycle");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  rot_unused_a: assert property (rd_ok && avs_address[7:2] == prc_pkg::IDX_ROT_CTRL |-> avs_readdata[5:3] == 3'h0)
    else $error("unused control bits read nonzero");
  top_bits_a: assert property (rd_ok && avs_address[7:2] == prc_pkg::IDX_START_TOP |-> avs_readdata[7:1] == 7'h00)
    else $error("start top register has extra bits");
  land_quiet_a: assert property (!portrait_mode |-> !alt_scheme && pclk_div_sel == 2'h0)
    else $error("portrait settings leak into landscape");
  split_off_a: assert property (portrait_mode && $past(portrait_mode) |-> !second_screen_en)
    else $error("second screen shown in portrait");
  boost_cause_a: assert property (mclk_div_sel == prc_pkg::MCLK_DIV_FAST |-> portrait_mode)
    else $error("memory clock boosted outside portrait");
  slow_idle_a: assert property (!cpu_mem_access [*5] |-> mclk_div_sel == prc_pkg::MCLK_DIV_SLOW)
    else $error("memory clock stays fast without access");
  fetch_gate_a: assert property (fetch_valid |-> $past(portrait_mode))
    else $error("refresh fetch in landscape");
  cover property (portrait_mode && alt_scheme);
  cover property (mclk_div_sel == prc_pkg::MCLK_DIV_FAST);
  cover property (second_screen_en);
endmodule : prc_properties
bind prc_rotation_ctrl prc_properties u_prop (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .cpu_mem_access, .portrait_mode, .alt_scheme, .pclk_div_sel,
  .mclk_div_sel, .second_screen_en, .fetch_valid);

// ===== tb/prc_panel_model.sv
// Panel side model: memory access and split pins, capture of line 0 fetches
`timescale 1ns/10ps
module prc_panel_model (
  input wire logic sys_clk,
  input wire logic want_cpu,
  input wire logic want_split,
  input wire logic fetch_valid,
  input wire logic fetch_first_line,
  input wire logic [prc_pkg::MEM_AW-1:0] fetch_addr,
  output logic cpu_mem_access,
  output logic split_active,
  output logic [prc_pkg::MEM_AW-1:0] line0_a,
  output logic [prc_pkg::MEM_AW-1:0] line0_b
);
  logic prev_q;
  initial begin
    cpu_mem_access = 1'b0;
    split_active = 1'b0;
    prev_q = 1'b0;
  end
  // Pins follow the bench one edge late, as a real bus bridge would
  always @(posedge sys_clk) begin
    cpu_mem_access <= want_cpu;
    split_active <= want_split;
    prev_q <= fetch_valid && fetch_first_line;
    if (fetch_valid && fetch_first_line && !prev_q) line0_a <= fetch_addr;
    if (fetch_valid && fetch_first_line && prev_q && line0_a == fetch_addr - 17'h80) line0_b <= fetch_addr;
  end
endmodule : prc_panel_model

// ===== tb/prc_rotation_ctrl_tb.sv
// Testbench for the portrait rotation control block
`timescale 1ns/10ps
module prc_rotation_ctrl_tb;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [3:0] o;} prc_row_t;
  logic sys_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, want_cpu = 0, want_split = 0;
  logic [7:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, portrait_mode, alt_scheme, second_screen_en, fetch_valid, fetch_first_line;
  logic cpu_mem_access, split_active;
  logic [1:0] pclk_div_sel, mclk_div_sel;
  logic [16:0] fetch_addr, line0_a, line0_b, ea;
  int n_errors = 0, n_tests = 0, cyc = 0;
  prc_row_t rows [11] = '{'{8'h30, 8'h7f, 8'h7f, 4'h0}, '{8'h34, 8'ha5, 8'ha5, 4'h0},
    '{8'h38, 8'hff, 8'h01, 4'h0}, '{8'h70, 8'h80, 8'h80, 4'h0}, '{8'h6c, 8'hff, 8'hc7, 4'hf},
    '{8'h6c, 8'h83, 8'h83, 4'hb}, '{8'h6c, 8'h7b, 8'h43, 4'h0}, '{8'h6c, 8'hc0, 8'hc0, 4'hc},
    '{8'h6c, 8'h80, 8'h80, 4'h8}, '{8'hfc, 8'h55, 8'h00, 4'h8}, '{8'h6c, 8'h00, 8'h00, 4'h0}};
  // Input clock doubles as the portrait clock
  always #12.5 sys_clk = ~sys_clk;
  prc_rotation_ctrl #(.PANEL_LINES(16'h0004)) u_dut (.sys_clk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_mem_access,
    .split_active, .portrait_mode, .alt_scheme, .pclk_div_sel, .mclk_div_sel, .second_screen_en,
    .fetch_addr, .fetch_valid, .fetch_first_line);
  prc_panel_model u_panel (.sys_clk, .want_cpu, .want_split, .fetch_valid, .fetch_first_line,
    .fetch_addr, .cpu_mem_access, .split_active, .line0_a, .line0_b);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    // Waitrequest and read data are both taken at the rising edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest && n < 50);
    q = avs_readdata;
    // An answer that never comes counts against the run
    if (avs_waitrequest) n_errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    chk(avs_waitrequest, 1);
    chk(mclk_div_sel, 1);
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      bus(0, rows[i].a, 0, rd);
      chk(rd, 0);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1, rows[i].a, rows[i].w, rd);
      bus(0, rows[i].a, 0, rd);
      chk(rd, {24'h0, rows[i].r});
      chk({portrait_mode, alt_scheme, pclk_div_sel}, rows[i].o);
    end
    $display("row test done");
    avs_byteenable <= 4'h0;
    bus(1, 8'h70, 8'h11, rd);
    avs_byteenable <= 4'hf;
    bus(0, 8'h70, 0, rd);
    chk(rd, 32'h80);
    want_split <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(second_screen_en, 1);
    bus(1, 8'h6c, 8'h80, rd);
    @(posedge sys_clk);
    chk(second_screen_en, 0);
    want_split <= 1'b0;
    $display("split test done");
    // Boost on a 40 MHz clock only to exercise the switch; boards keep it at 25 MHz or less
    for (int i = 0; i < 2; i++) begin
      bus(1, 8'h6c, i ? 8'h84 : 8'h80, rd);
      want_cpu <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk(mclk_div_sel, i ? 0 : 1);
      want_cpu <= 1'b0;
      repeat (7) @(posedge sys_clk);
      chk(mclk_div_sel, 1);
    end
    $display("clock test done");
    // Stride a power of two, start loaded with stride less one
    bus(1, 8'h80, 8'h04, rd);
    bus(1, 8'h30, 8'h7f, rd);
    bus(1, 8'h34, 8'h00, rd);
    bus(1, 8'h38, 8'h00, rd);
    // One clock serves both schemes here; rate doubling is a board matter
    for (int s = 0; s < 2; s++) begin
      bus(1, 8'h6c, 8'h00, rd);
      bus(1, 8'h6c, s ? 8'hc0 : 8'h80, rd);
      repeat (80) @(posedge sys_clk);
      ea = s ? 17'h0007f : 17'h0007e;
      chk(line0_a, ea);
      chk(line0_b, ea + 17'h80);
    end
    $display("refresh test done");
    conclude();
  end
endmodule : prc_rotation_ctrl_tb
